// ### src/ssm_mac_decoder.sv
// combinational decode of the mac, barrel shifter and test opcodes
`timescale 1ns/1ps
`include "ssm_params.svh"
module ssm_mac_decoder
	import ssm_pkg::*;
(
	input wire logic [15:0] opcode,
	output ssm_mac_op_t mac_op
);
	logic pre_mac;
	logic pre_mreg;
	logic bit4;
	logic bit7;
	logic [3:0] low;
	// prefix fields; bit 5 is the return flag and does not matter here
	always_comb begin
		pre_mac = opcode[15:12] == `SSM_GRP_MAC
			&& opcode[11:8] == `SSM_SUB_MAC && !opcode[6];
		pre_mreg = opcode[15:12] == `SSM_GRP_MAC
			&& opcode[11:8] == `SSM_SUB_MREG && !opcode[6];
		bit4 = opcode[4];
		bit7 = opcode[7];
		low = opcode[3:0];
	end
	// opcode table lookup
	always_comb begin
		mac_op = SSM_OP_NONE;
		if (pre_mac && !bit4 && !bit7) begin
			unique case (low)
				4'h8: mac_op = SSM_OP_ZERO_EQ;
				4'h9: mac_op = SSM_OP_DSRA;
				4'ha: mac_op = SSM_OP_DSRL;
				4'hc: mac_op = SSM_OP_CLR_ACC;
				4'he: mac_op = SSM_OP_DSLL;
				4'hf: mac_op = SSM_OP_FP_NORM;
				default: mac_op = SSM_OP_NONE;
			endcase
		end else if (pre_mac && bit4 && !bit7) begin
			unique case (low)
				4'h1: mac_op = SSM_OP_MAC_SHR;
				4'h2: mac_op = SSM_OP_SMAC_STACK;
				4'h3: mac_op = SSM_OP_MUL_MIXED;
				4'h4: mac_op = SSM_OP_MSUB_SGN;
				4'h5: mac_op = SSM_OP_MAC_MIXED;
				4'h6: mac_op = SSM_OP_MAC_UNS;
				4'h7: mac_op = SSM_OP_MAC_SGN;
				default: mac_op = SSM_OP_NONE;
			endcase
		end else if (pre_mac && bit4 && bit7) begin
			unique case (low)
				4'h2: mac_op = SSM_OP_SMAC_BUS;
				4'h6: mac_op = SSM_OP_MUL_UNS;
				4'h7: mac_op = SSM_OP_MUL_SGN;
				default: mac_op = SSM_OP_NONE;
			endcase
		end else if (pre_mreg && bit4) begin
			unique case (low)
				`SSM_MREG_X: mac_op = bit7 ? SSM_OP_ST_EXT : SSM_OP_LD_EXT;
				`SSM_MREG_L: mac_op = bit7 ? SSM_OP_ST_LOW : SSM_OP_LD_LOW;
				`SSM_MREG_H: mac_op = bit7 ? SSM_OP_ST_HIGH : SSM_OP_LD_HIGH;
				default: mac_op = SSM_OP_NONE;
			endcase
		end
	end
endmodule

// ### src/ssm_params.svh
// shared constants for the shift stage and opcode decoder
`ifndef SSM_PARAMS_SVH
`define SSM_PARAMS_SVH
`define SSM_WIDTH 16
`define SSM_MSB 15
`define SSM_CARRY_RST 1'b0
`define SSM_TOP_RST 16'h0000
`define SSM_NEXT_RST 16'h0000
`define SSM_GRP_MAC 4'hb
`define SSM_SUB_MAC 4'h0
`define SSM_SUB_MREG 4'he
`define SSM_MREG_X 4'h2
`define SSM_MREG_L 4'h6
`define SSM_MREG_H 4'h7
`endif

// ### src/ssm_pkg.sv
// types for the shift stage and mac opcode decoder
package ssm_pkg;
	typedef enum logic [3:0] {
		SSM_SH_NONE = 4'h0,
		SSM_SH_SIGN_EXT = 4'h1,
		SSM_SH_ARITH_LEFT = 4'h2,
		SSM_SH_ROTATE_LEFT = 4'h3,
		SSM_SH_RIGHT_OUT_CARRY = 4'h4,
		SSM_SH_ROTATE_RIGHT_CARRY = 4'h5,
		SSM_SH_LOGICAL_RIGHT = 4'h6,
		SSM_SH_ARITH_RIGHT = 4'h7,
		SSM_SH_SECOND_LEFT = 4'h8,
		SSM_SH_SECOND_ROTATE_LEFT = 4'h9,
		SSM_SH_DOUBLE_LEFT = 4'ha,
		SSM_SH_DOUBLE_ROTATE_LEFT = 4'hb,
		SSM_SH_DOUBLE_RIGHT_OUT_CARRY = 4'hc,
		SSM_SH_DOUBLE_ROTATE_RIGHT = 4'hd,
		SSM_SH_DOUBLE_LOGICAL_RIGHT = 4'he,
		SSM_SH_DOUBLE_ARITH_RIGHT = 4'hf
	} ssm_shift_t;
	typedef enum logic [4:0] {
		SSM_OP_NONE = 5'h00,
		SSM_OP_ZERO_EQ = 5'h01,
		SSM_OP_DSRA = 5'h02,
		SSM_OP_DSRL = 5'h03,
		SSM_OP_CLR_ACC = 5'h04,
		SSM_OP_DSLL = 5'h05,
		SSM_OP_FP_NORM = 5'h06,
		SSM_OP_MAC_SHR = 5'h07,
		SSM_OP_SMAC_STACK = 5'h08,
		SSM_OP_SMAC_BUS = 5'h09,
		SSM_OP_MUL_MIXED = 5'h0a,
		SSM_OP_MUL_UNS = 5'h0b,
		SSM_OP_MUL_SGN = 5'h0c,
		SSM_OP_MSUB_SGN = 5'h0d,
		SSM_OP_MAC_MIXED = 5'h0e,
		SSM_OP_MAC_UNS = 5'h0f,
		SSM_OP_MAC_SGN = 5'h10,
		SSM_OP_LD_EXT = 5'h11,
		SSM_OP_LD_LOW = 5'h12,
		SSM_OP_LD_HIGH = 5'h13,
		SSM_OP_ST_EXT = 5'h14,
		SSM_OP_ST_LOW = 5'h15,
		SSM_OP_ST_HIGH = 5'h16
	} ssm_mac_op_t;
endpackage

// ### src/ssm_shift_stage.sv
// shift stage after the alu with top, second and carry registers
// Summary of operation
// - code 0000: top takes alu result, carry unchanged
// - codes 0000-0111 leave second register unchanged
// - 0001 sign-extends bit 15; 0111 puts bit 15 in carry and top 15
// - 0010 shift left, bit 15 to carry; 0011 rotates old carry in
// - 0100/0101/0110 right shifts with carry, bit0 or zero handling
// - 1000/1001 shift second left with zero or carry fill
// - 1010/1011 32-bit left shift of top:second pair
// - 1100 32-bit right shift, old carry in, carry cleared
// - 1101 32-bit rotate right, second bit 0 into carry
// - 1110 logical, 1111 arithmetic 32-bit right shift
// - prefix b0, 00r0, low 1001 is double arithmetic right shift
// - low 1010 is double logical right shift
// - low 1110 double left shift, 1111 floating normalise
// - 00r1 with 0001 shifts mac output registers right
// - 00r1 with 0010 streams mac between stack and memory
// - 10r1 with 0010 streams mac between bus and memory
// - 00r1 with 0100..0111 selects accumulate operation
// - 00r1/0011 mixed multiply; 10r1 0110 unsigned, 0111 signed
`timescale 1ns/1ps
`include "ssm_params.svh"
module ssm_shift_stage
	import ssm_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic exec,
	input wire logic [3:0] shift_code,
	input wire logic [15:0] alu_z,
	input wire logic load_second,
	input wire logic [15:0] second_load_value,
	input wire logic load_carry,
	input wire logic carry_load_value,
	input wire logic [15:0] opcode,
	input wire logic opcode_valid,
	output logic [15:0] top_q,
	output logic [15:0] second_q,
	output logic prior_carry,
	output ssm_mac_op_t mac_op_q,
	output logic mac_op_valid_q
);
	logic [15:0] top_d;
	logic [15:0] second_d;
	logic carry_d;
	logic [15:0] sh_top;
	logic [15:0] sh_second;
	logic sh_carry;
	ssm_mac_op_t dec_op;
	ssm_mac_op_t mac_op_d;
	logic mac_op_valid_d;
	logic carry_q;

	// shift function
	ssm_shifter u_shifter (
		.code(shift_code),
		.alu_z(alu_z),
		.second_in(second_q),
		.prior_carry(carry_q),
		.top_out(sh_top),
		.second_out(sh_second),
		.carry_out(sh_carry)
	);

	// opcode decode
	ssm_mac_decoder u_decoder (
		.opcode(opcode),
		.mac_op(dec_op)
	);

	// next state for the stack registers and carry
	always_comb begin
		top_d = top_q;
		second_d = second_q;
		carry_d = carry_q;
		if (load_second)
			second_d = second_load_value;
		if (load_carry)
			carry_d = carry_load_value;
		if (exec) begin
			top_d = sh_top;
			second_d = sh_second;
			carry_d = sh_carry;
		end
	end

	// registers
	always_ff @(posedge clk) begin
		if (reset) begin
			top_q <= `SSM_TOP_RST;
			second_q <= `SSM_NEXT_RST;
			carry_q <= `SSM_CARRY_RST;
		end else begin
			top_q <= top_d;
			second_q <= second_d;
			carry_q <= carry_d;
		end
	end
	assign prior_carry = carry_q;

	// decoded mac operation, registered
	always_comb begin
		mac_op_d = opcode_valid ? dec_op : SSM_OP_NONE;
		mac_op_valid_d = opcode_valid && dec_op != SSM_OP_NONE;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			mac_op_q <= SSM_OP_NONE;
			mac_op_valid_q <= 1'b0;
		end else begin
			mac_op_q <= mac_op_d;
			mac_op_valid_q <= mac_op_valid_d;
		end
	end

	// checks
	property p_noshift;
		@(posedge clk) disable iff (reset)
		exec && shift_code == 4'h0 |=> top_q == $past(alu_z)
			&& prior_carry == $past(prior_carry);
	endproperty
	a_noshift: assert property (p_noshift) else $error("no shift wrong");
	property p_second_keep;
		@(posedge clk) disable iff (reset)
		exec && !shift_code[3] |=> second_q == $past(second_q);
	endproperty
	a_second_keep: assert property (p_second_keep)
		else $error("second changed");
	property p_signext;
		@(posedge clk) disable iff (reset)
		exec && shift_code == 4'h1 |=> top_q == {16{$past(alu_z[15])}};
	endproperty
	a_signext: assert property (p_signext) else $error("sign ext wrong");
	property p_left;
		@(posedge clk) disable iff (reset)
		exec && shift_code == 4'h3 |=> prior_carry == $past(alu_z[15])
			&& top_q == {$past(alu_z[14:0]), $past(prior_carry)};
	endproperty
	a_left: assert property (p_left) else $error("rotate left wrong");
	property p_rshift;
		@(posedge clk) disable iff (reset)
		exec && shift_code == 4'h4 |=> !prior_carry
			&& top_q[15] == $past(prior_carry);
	endproperty
	a_rshift: assert property (p_rshift) else $error("right out wrong");
	property p_second_left;
		@(posedge clk) disable iff (reset)
		exec && shift_code == 4'h8 |=> second_q == {$past(second_q[14:0]), 1'b0}
			&& top_q == $past(alu_z);
	endproperty
	a_second_left: assert property (p_second_left)
		else $error("second left wrong");
	property p_dleft;
		@(posedge clk) disable iff (reset)
		exec && shift_code == 4'ha |=> top_q[0] == $past(second_q[15])
			&& second_q[0] == 1'b0 && prior_carry == $past(alu_z[15]);
	endproperty
	a_dleft: assert property (p_dleft) else $error("double left wrong");
	property p_drot;
		@(posedge clk) disable iff (reset)
		exec && shift_code == 4'hd |=> prior_carry == $past(second_q[0])
			&& second_q[15] == $past(alu_z[0]);
	endproperty
	a_drot: assert property (p_drot) else $error("double rotate wrong");
	property p_dsra;
		@(posedge clk) disable iff (reset)
		opcode_valid && opcode == 16'hb009 |=> mac_op_q == SSM_OP_DSRA
			&& mac_op_valid_q;
	endproperty
	a_dsra: assert property (p_dsra) else $error("dsra decode wrong");
	property p_arith_left;
		@(posedge clk) disable iff (reset)
		exec && shift_code == 4'h2 |=> prior_carry == $past(alu_z[15])
			&& top_q == {$past(alu_z[14:0]), 1'b0};
	endproperty
	a_arith_left: assert property (p_arith_left)
		else $error("arith left wrong");
	property p_rrot;
		@(posedge clk) disable iff (reset)
		exec && shift_code == 4'h5 |=> prior_carry == $past(alu_z[0])
			&& top_q == {$past(prior_carry), $past(alu_z[15:1])};
	endproperty
	a_rrot: assert property (p_rrot)
		else $error("rotate right wrong");
	property p_lright;
		@(posedge clk) disable iff (reset)
		exec && shift_code == 4'h6 |=> !prior_carry
			&& top_q == {1'b0, $past(alu_z[15:1])};
	endproperty
	a_lright: assert property (p_lright)
		else $error("logical right wrong");
	property p_arith_right;
		@(posedge clk) disable iff (reset)
		exec && shift_code == 4'h7 |=> prior_carry == $past(alu_z[15])
			&& top_q == {$past(alu_z[15]), $past(alu_z[15:1])};
	endproperty
	a_arith_right: assert property (p_arith_right)
		else $error("arith right wrong");
	property p_second_rot;
		@(posedge clk) disable iff (reset)
		exec && shift_code == 4'h9 |=> prior_carry == $past(prior_carry)
			&& second_q == {$past(second_q[14:0]), $past(prior_carry)};
	endproperty
	a_second_rot: assert property (p_second_rot)
		else $error("second rotate wrong");
	property p_drot_left;
		@(posedge clk) disable iff (reset)
		exec && shift_code == 4'hb |=> prior_carry == $past(alu_z[15])
			&& top_q == {$past(alu_z[14:0]), $past(second_q[15])}
			&& second_q == {$past(second_q[14:0]), $past(prior_carry)};
	endproperty
	a_drot_left: assert property (p_drot_left)
		else $error("double rotate left wrong");
	property p_dright_out;
		@(posedge clk) disable iff (reset)
		exec && shift_code == 4'hc |=> !prior_carry
			&& top_q == {$past(prior_carry), $past(alu_z[15:1])}
			&& second_q == {$past(alu_z[0]), $past(second_q[15:1])};
	endproperty
	a_dright_out: assert property (p_dright_out)
		else $error("double right out wrong");
	property p_dlogical_right;
		@(posedge clk) disable iff (reset)
		exec && shift_code == 4'he |=> !prior_carry
			&& top_q == {1'b0, $past(alu_z[15:1])}
			&& second_q == {$past(alu_z[0]), $past(second_q[15:1])};
	endproperty
	a_dlogical_right: assert property (p_dlogical_right)
		else $error("double logical right wrong");
	property p_darith_right;
		@(posedge clk) disable iff (reset)
		exec && shift_code == 4'hf |=> prior_carry == $past(alu_z[15])
			&& top_q == {$past(alu_z[15]), $past(alu_z[15:1])}
			&& second_q == {$past(alu_z[0]), $past(second_q[15:1])};
	endproperty
	a_darith_right: assert property (p_darith_right)
		else $error("double arith right wrong");
	// decode checks; bit 5 is the return flag and is masked out
	property p_dsrl;
		@(posedge clk) disable iff (reset)
		opcode_valid && (opcode & 16'hffdf) == 16'hb00a
			|=> mac_op_q == SSM_OP_DSRL && mac_op_valid_q;
	endproperty
	a_dsrl: assert property (p_dsrl)
		else $error("dsrl decode wrong");
	property p_dsll_norm;
		@(posedge clk) disable iff (reset)
		opcode_valid && (opcode & 16'hffde) == 16'hb00e
			|=> mac_op_q == ($past(opcode[0]) ? SSM_OP_FP_NORM : SSM_OP_DSLL);
	endproperty
	a_dsll_norm: assert property (p_dsll_norm)
		else $error("dsll or normalise decode wrong");
	property p_mac_shr;
		@(posedge clk) disable iff (reset)
		opcode_valid && (opcode & 16'hffdf) == 16'hb011
			|=> mac_op_q == SSM_OP_MAC_SHR && mac_op_valid_q;
	endproperty
	a_mac_shr: assert property (p_mac_shr)
		else $error("mac shift decode wrong");
	property p_smac_stack;
		@(posedge clk) disable iff (reset)
		opcode_valid && (opcode & 16'hffdf) == 16'hb012
			|=> mac_op_q == SSM_OP_SMAC_STACK && mac_op_valid_q;
	endproperty
	a_smac_stack: assert property (p_smac_stack)
		else $error("stack stream decode wrong");
	property p_smac_bus;
		@(posedge clk) disable iff (reset)
		opcode_valid && (opcode & 16'hffdf) == 16'hb092
			|=> mac_op_q == SSM_OP_SMAC_BUS && mac_op_valid_q;
	endproperty
	a_smac_bus: assert property (p_smac_bus)
		else $error("bus stream decode wrong");
	property p_mac_acc;
		@(posedge clk) disable iff (reset)
		opcode_valid && (opcode & 16'hffdc) == 16'hb014
			|=> mac_op_q == ssm_mac_op_t'(5'h0d + 5'($past(opcode[1:0])));
	endproperty
	a_mac_acc: assert property (p_mac_acc)
		else $error("accumulate decode wrong");
	property p_mul_mixed;
		@(posedge clk) disable iff (reset)
		opcode_valid && (opcode & 16'hffdf) == 16'hb013
			|=> mac_op_q == SSM_OP_MUL_MIXED && mac_op_valid_q;
	endproperty
	a_mul_mixed: assert property (p_mul_mixed)
		else $error("mixed multiply decode wrong");
	property p_mul_plain;
		@(posedge clk) disable iff (reset)
		opcode_valid && (opcode & 16'hffde) == 16'hb096
			|=> mac_op_q == ($past(opcode[0]) ? SSM_OP_MUL_SGN : SSM_OP_MUL_UNS);
	endproperty
	a_mul_plain: assert property (p_mul_plain)
		else $error("multiply decode wrong");
	property p_mreg_ext;
		@(posedge clk) disable iff (reset)
		opcode_valid && (opcode & 16'hff5f) == 16'hbe12
			|=> mac_op_q == ($past(opcode[7]) ? SSM_OP_ST_EXT : SSM_OP_LD_EXT);
	endproperty
	a_mreg_ext: assert property (p_mreg_ext)
		else $error("extension register decode wrong");
	property p_mreg_high;
		@(posedge clk) disable iff (reset)
		opcode_valid && (opcode & 16'hff5f) == 16'hbe17
			|=> mac_op_q == ($past(opcode[7]) ? SSM_OP_ST_HIGH : SSM_OP_LD_HIGH);
	endproperty
	a_mreg_high: assert property (p_mreg_high)
		else $error("high register decode wrong");
	property p_zero_clr;
		@(posedge clk) disable iff (reset)
		opcode_valid && (opcode & 16'hffdb) == 16'hb008
			|=> mac_op_q == ($past(opcode[2]) ? SSM_OP_CLR_ACC : SSM_OP_ZERO_EQ);
	endproperty
	a_zero_clr: assert property (p_zero_clr)
		else $error("zero test or clear decode wrong");
	property p_op_none;
		@(posedge clk) disable iff (reset)
		!opcode_valid |=> mac_op_q == SSM_OP_NONE && !mac_op_valid_q;
	endproperty
	a_op_none: assert property (p_op_none)
		else $error("op without valid opcode");
	c_dshift: cover property (@(posedge clk) exec && shift_code == 4'hf);
	c_rot: cover property (@(posedge clk) exec && shift_code == 4'hb);
	c_mac: cover property (@(posedge clk) mac_op_q == SSM_OP_MAC_SGN);
	c_store: cover property (@(posedge clk) mac_op_q == SSM_OP_ST_HIGH);
	c_exec_load: cover property (@(posedge clk) exec && load_second);
endmodule

// ### src/ssm_shifter.sv
// combinational shift function for top, second and carry
`timescale 1ns/1ps
module ssm_shifter
	import ssm_pkg::*;
(
	input wire logic [3:0] code,
	input wire logic [15:0] alu_z,
	input wire logic [15:0] second_in,
	input wire logic prior_carry,
	output logic [15:0] top_out,
	output logic [15:0] second_out,
	output logic carry_out
);
	// per-code result selection
	always_comb begin
		top_out = alu_z;
		second_out = second_in;
		carry_out = prior_carry;
		unique case (ssm_shift_t'(code))
			SSM_SH_NONE: begin
			end
			SSM_SH_SIGN_EXT: top_out = {16{alu_z[15]}};
			SSM_SH_ARITH_LEFT: begin
				top_out = {alu_z[14:0], 1'b0};
				carry_out = alu_z[15];
			end
			SSM_SH_ROTATE_LEFT: begin
				top_out = {alu_z[14:0], prior_carry};
				carry_out = alu_z[15];
			end
			SSM_SH_RIGHT_OUT_CARRY: begin
				top_out = {prior_carry, alu_z[15:1]};
				carry_out = 1'b0;
			end
			SSM_SH_ROTATE_RIGHT_CARRY: begin
				top_out = {prior_carry, alu_z[15:1]};
				carry_out = alu_z[0];
			end
			SSM_SH_LOGICAL_RIGHT: begin
				top_out = {1'b0, alu_z[15:1]};
				carry_out = 1'b0;
			end
			SSM_SH_ARITH_RIGHT: begin
				top_out = {alu_z[15], alu_z[15:1]};
				carry_out = alu_z[15];
			end
			SSM_SH_SECOND_LEFT: second_out = {second_in[14:0], 1'b0};
			SSM_SH_SECOND_ROTATE_LEFT:
				second_out = {second_in[14:0], prior_carry};
			SSM_SH_DOUBLE_LEFT: begin
				top_out = {alu_z[14:0], second_in[15]};
				second_out = {second_in[14:0], 1'b0};
				carry_out = alu_z[15];
			end
			SSM_SH_DOUBLE_ROTATE_LEFT: begin
				top_out = {alu_z[14:0], second_in[15]};
				second_out = {second_in[14:0], prior_carry};
				carry_out = alu_z[15];
			end
			SSM_SH_DOUBLE_RIGHT_OUT_CARRY: begin
				top_out = {prior_carry, alu_z[15:1]};
				second_out = {alu_z[0], second_in[15:1]};
				carry_out = 1'b0;
			end
			SSM_SH_DOUBLE_ROTATE_RIGHT: begin
				top_out = {prior_carry, alu_z[15:1]};
				second_out = {alu_z[0], second_in[15:1]};
				carry_out = second_in[0];
			end
			SSM_SH_DOUBLE_LOGICAL_RIGHT: begin
				top_out = {1'b0, alu_z[15:1]};
				second_out = {alu_z[0], second_in[15:1]};
				carry_out = 1'b0;
			end
			SSM_SH_DOUBLE_ARITH_RIGHT: begin
				top_out = {alu_z[15], alu_z[15:1]};
				second_out = {alu_z[0], second_in[15:1]};
				carry_out = alu_z[15];
			end
		endcase
	end
endmodule

// ### testbench/ssm_seq_model.sv
// sequencer model that drives the shift stage and decoder inputs
`timescale 1ns/1ps
module ssm_seq_model (
	input wire logic clk,
	output logic exec,
	output logic [3:0] shift_code,
	output logic [15:0] alu_z,
	output logic load_second,
	output logic [15:0] second_load_value,
	output logic load_carry,
	output logic carry_load_value,
	output logic [15:0] opcode,
	output logic opcode_valid
);
	// idle values from time zero
	initial begin
		exec = 1'b0;
		shift_code = 4'h0;
		alu_z = 16'h0000;
		load_second = 1'b0;
		second_load_value = 16'h0000;
		load_carry = 1'b0;
		carry_load_value = 1'b0;
		opcode = 16'h0000;
		opcode_valid = 1'b0;
	end
	// preload second and carry, then one shift, loads clash if asked
	task automatic shift(input logic [3:0] code, input logic [15:0] z,
		input logic [15:0] n, input logic c, input logic clash);
		@(posedge clk);
		#1;
		load_second = 1'b1;
		second_load_value = n;
		load_carry = 1'b1;
		carry_load_value = c;
		@(posedge clk);
		#1;
		exec = 1'b1;
		shift_code = code;
		alu_z = z;
		load_second = clash;
		second_load_value = ~n;
		load_carry = clash;
		carry_load_value = ~c;
		@(posedge clk);
		#1;
		exec = 1'b0;
		load_second = 1'b0;
		load_carry = 1'b0;
		alu_z = ~z; // stale result must not be relied on
	endtask
	// present one opcode for a single edge
	task automatic decode(input logic [15:0] op);
		@(posedge clk);
		#1;
		opcode = op;
		opcode_valid = 1'b1;
		@(posedge clk);
		#1;
		opcode_valid = 1'b0;
		opcode = ~op;
	endtask
endmodule

// ### testbench/stack_shift_and_mac_decode_tb_top.sv
// self-checking bench for the shift stage and mac opcode decoder
`timescale 1ns/1ps
module stack_shift_and_mac_decode_tb_top
	import ssm_pkg::*;
;
	logic clk, reset, exec, load_second, load_carry, carry_load_value;
	logic opcode_valid, prior_carry, mac_op_valid_q, c;
	logic [3:0] shift_code;
	logic [15:0] alu_z, second_load_value, opcode, top_q, second_q;
	logic [15:0] rnd, z, n, op;
	logic [32:0] e;
	ssm_mac_op_t mac_op_q;
	int err_count, checks, cycles;
	logic [15:0] opc [22] = '{16'hb008, 16'hb009, 16'hb00a, 16'hb00c,
		16'hb00e, 16'hb00f, 16'hb011, 16'hb012, 16'hb092, 16'hb013,
		16'hb096, 16'hb097, 16'hb014, 16'hb015, 16'hb016, 16'hb017,
		16'hbe12, 16'hbe16, 16'hbe17, 16'hbe92, 16'hbe96, 16'hbe97};

	ssm_shift_stage u_dut (.clk(clk), .reset(reset), .exec(exec),
		.shift_code(shift_code), .alu_z(alu_z), .load_second(load_second),
		.second_load_value(second_load_value), .load_carry(load_carry),
		.carry_load_value(carry_load_value), .opcode(opcode),
		.opcode_valid(opcode_valid), .top_q(top_q), .second_q(second_q),
		.prior_carry(prior_carry), .mac_op_q(mac_op_q),
		.mac_op_valid_q(mac_op_valid_q));
	ssm_seq_model u_seq (.clk(clk), .exec(exec), .shift_code(shift_code),
		.alu_z(alu_z), .load_second(load_second),
		.second_load_value(second_load_value), .load_carry(load_carry),
		.carry_load_value(carry_load_value), .opcode(opcode),
		.opcode_valid(opcode_valid));

	// 40 mhz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// next lfsr state
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// expected {carry, top, second} after one shift
	function automatic logic [32:0] exp_shift(input logic [3:0] k,
		input logic [15:0] z, input logic [15:0] n, input logic c);
		case (k)
			4'h0: return {c, z, n};
			4'h1: return {c, {16{z[15]}}, n};
			4'h2: return {z, 1'b0, n};
			4'h3: return {z, c, n};
			4'h4: return {1'b0, c, z[15:1], n};
			4'h5: return {z[0], c, z[15:1], n};
			4'h6: return {2'b00, z[15:1], n};
			4'h7: return {z[15], z[15], z[15:1], n};
			4'h8: return {c, z, n[14:0], 1'b0};
			4'h9: return {c, z, n[14:0], c};
			4'ha: return {z, n, 1'b0};
			4'hb: return {z, n, c};
			4'hc: return {1'b0, c, z, n[15:1]};
			4'hd: return {n[0], c, z, n[15:1]};
			4'he: return {2'b00, z, n[15:1]};
			default: return {z[15], z[15], z, n[15:1]};
		endcase
	endfunction
	// compare and count
	task automatic chk(input string name, input logic [32:0] seen,
		input logic [32:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// counts and verdict
	task automatic results();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			err_count++;
			results();
		end
	end
	// main sequence
	initial begin
		reset = 1'b1;
		err_count = 0;
		checks = 0;
		cycles = 0;
		rnd = 16'h19d9;
		repeat (12) @(posedge clk);
		#1;
		reset = 1'b0;
		chk("reset", {prior_carry, top_q, second_q}, 33'h0);
		chk("reset_valid", {32'h0, mac_op_valid_q}, 33'h0);
		// every code three times; last pass uses edge patterns
		for (int i = 0; i < 48; i++) begin
			rnd = lfsr(rnd);
			n = rnd;
			rnd = lfsr(rnd);
			z = rnd;
			c = rnd[3];
			if (i >= 32) begin
				z = 16'h8001;
				n = 16'h8001;
			end
			u_seq.shift(4'(i), z, n, c, i[4]);
			chk("shift", {prior_carry, top_q, second_q},
				exp_shift(4'(i), z, n, c));
		end
		$display("shift tests done");
		// every decoded opcode with return flag clear, then set, then
		// one unrecognised
		for (int j = 0; j < 45; j++) begin
			op = j < 44 ? opc[j % 22] | (j < 22 ? 16'h0000 : 16'h0020)
				: 16'hb0ff;
			e = {28'h0, j < 44 ? 5'(j % 22 + 1) : 5'h00};
			u_seq.decode(op);
			if (j % 22 < 6)
				chk("shift_op", {28'h0, mac_op_q}, e);
			else
				chk("mac_op", {28'h0, mac_op_q}, e);
			chk("mac_valid", {32'h0, mac_op_valid_q}, {32'h0, j < 44});
			@(posedge clk);
			#1;
			chk("valid_drop", {32'h0, mac_op_valid_q}, 33'h0);
		end
		$display("decode tests done");
		results();
	end
endmodule
